// ### verilog/bf_pkg.sv
/*
  shared constants for the breaker failure pick-up block: register map,
  field positions, reset values, time base and enumerations.
  assumes a 200 MHz clock and magnitudes in steps of 0.001 x nominal.
*/
package bf_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 20;
  localparam int MAG_W = 16;
  localparam int PH_THR_W = 12;
  localparam int DLY_W = 19;
  localparam int GROUPS = 2;

  // time base
  localparam int CLK_PERIOD_PS = 5000;
  localparam int UPDATE_PERIOD_MS = 5;
  localparam int TICK_CYCLES = (UPDATE_PERIOD_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int RETRIP_DELAY_MS = 100;
  localparam int FAIL_DELAY_MS = 200;
  localparam logic [DLY_W-1:0] RETRIP_DLY_RST = DLY_W'(RETRIP_DELAY_MS / UPDATE_PERIOD_MS);
  localparam logic [DLY_W-1:0] FAIL_DLY_RST = DLY_W'(FAIL_DELAY_MS / UPDATE_PERIOD_MS);

  // thresholds: phase in 0.01 x nominal, residual in 0.001 x nominal
  localparam logic [PH_THR_W-1:0] PH_THR_RST = 12'h014;
  localparam logic [MAG_W-1:0] RES_THR_RST = 16'h04b0;
  localparam int PHASE_SCALE = 10;
  localparam int RESET_RATIO_PCT = 97;
  localparam int PCT_FULL = 100;

  // register map
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RES_SEL = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_SIG_MASK = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_DO_MASK = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_RETRIP_DLY = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_FAIL_DLY = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h7;
  localparam logic [1:0] GRP_FIELD_PH = 2'h0;
  localparam logic [1:0] GRP_FIELD_RES = 2'h1;
  localparam logic [1:0] GRP_FIELD_MODE = 2'h2;
  localparam int GRP_BASE_BIT = 3;

  // control and status register fields
  localparam int CTRL_RETRIP_EN_BIT = 0;
  localparam int CTRL_FORCE_EN_BIT = 1;
  localparam int CTRL_FORCE_LSB = 2;
  localparam int CTRL_GROUP_BIT = 5;
  localparam int STAT_PU_BIT = 3;
  localparam int STAT_PH_LSB = 4;
  localparam int STAT_RES_BIT = 7;

  typedef enum logic [1:0] {
    RES_DISABLED = 2'b00,
    RES_INPUT_ONE = 2'b01,
    RES_INPUT_TWO = 2'b10,
    RES_FROM_PHASES = 2'b11
  } res_sel_e;

  typedef enum logic [3:0] {
    MODE_CUR = 4'b0000,
    MODE_DO = 4'b0001,
    MODE_SIG = 4'b0010,
    MODE_CUR_AND_DO = 4'b0011,
    MODE_CUR_AND_SIG = 4'b0100,
    MODE_CUR_OR_SIG = 4'b0101,
    MODE_CUR_OR_SIG_OR_DO = 4'b0110,
    MODE_SIG_OR_DO = 4'b0111,
    MODE_CUR_OR_DO = 4'b1000,
    MODE_CUR_AND_SIG_AND_DO = 4'b1001
  } mode_e;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b000,
    ST_START = 3'b001,
    ST_RETRIP = 3'b010,
    ST_FAILURE = 3'b011,
    ST_BLOCKED = 3'b100
  } status_e;
endpackage

// ### verilog/bf_timer_if.sv
/*
  carrier between the pick-up logic and one delay timer.
  assumes all members are driven on the same clock.
*/
`timescale 1ns/1ps
interface bf_timer_if #(parameter int W = 19);
  logic tick;
  logic pickup;
  logic [W-1:0] delay;
  logic expired;
  modport ctrl(output tick, output pickup, output delay, input expired);
  modport timer(input tick, input pickup, input delay, output expired);
endinterface

// ### verilog/bf_delay_timer.sv
/*
  definite delay timer counting update ticks while pick-up is held.
  assumes tick is a one-cycle enable and pickup is valid beside it.
*/
`timescale 1ns/1ps
module bf_delay_timer #(
  parameter int W = 19
) (
  input wire logic clk,
  input wire logic reset_n,
  bf_timer_if.timer tmr
);
  logic [W-1:0] count_reg;
  logic expired_reg;

  // elapsed ticks, cleared at once on release
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else if (tmr.tick) begin
      if (!tmr.pickup) begin
        count_reg <= '0;
      end else if (count_reg != {W{1'b1}}) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      expired_reg <= 1'b0;
    end else if (tmr.tick) begin
      expired_reg <= tmr.pickup && (count_reg >= tmr.delay);
    end
  end

  assign tmr.expired = expired_reg;
endmodule // bf_delay_timer

// ### verilog/bf_pickup.sv
/*
  breaker failure supervision: current pick-up with hysteresis, mode
  combination with trip signals and relay states, retrip and failure outputs,
  forced status and a small register port.
  assumes magnitude and binary inputs come from logic on CLK.
*/
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - any phase above the shared phase threshold raises current pick-up
// - a pick-up drops only below 97 percent of its threshold
// - the selected residual current is compared against its own threshold
// - residual source is off, input one, input two or phase sum; off at reset
// - magnitudes are evaluated once per 5 ms update tick
// - mode selects current, signal, relay criteria or their combinations
// - masked trip signals count only in modes that include signals
// - masked relay states count only in modes that include relays
// - forced status applies only while global forcing is enabled
// - selection and force settings are static, outside the groups
// - thresholds and mode follow the active group, applied at once
// - phase threshold in 0.01 nominal steps, default 0.20
// - residual threshold in 0.001 nominal steps, default 1.200
// - retrip output to own breaker, failure output to upstream breaker
// - retrip can be disabled while failure output still works
// - one pick-up starts both timers, 100 ms and 200 ms defaults
// - both timers clear as soon as pick-up releases
module bf_pickup
  import bf_pkg::*;
#(
  parameter int N_SIG = 8,
  parameter int N_RELAY = 8,
  parameter int TICK_DIV = bf_pkg::TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [bf_pkg::ADDR_W-1:0] ADDR,
  input wire logic [bf_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [bf_pkg::DATA_W-1:0] RDATA,
  input wire logic [bf_pkg::MAG_W-1:0] PHASE_A_MAG,
  input wire logic [bf_pkg::MAG_W-1:0] PHASE_B_MAG,
  input wire logic [bf_pkg::MAG_W-1:0] PHASE_C_MAG,
  input wire logic [bf_pkg::MAG_W-1:0] RESIDUAL_INPUT_ONE,
  input wire logic [bf_pkg::MAG_W-1:0] RESIDUAL_INPUT_TWO,
  input wire logic [bf_pkg::MAG_W-1:0] RESIDUAL_FROM_PHASES,
  input wire logic [N_SIG-1:0] TRIP_SIGNALS,
  input wire logic [N_RELAY-1:0] RELAY_STATES,
  input wire logic BLOCK,
  output logic START,
  output logic RETRIP,
  output logic BREAKER_FAILURE_OUTPUT,
  output logic [2:0] STATUS
);
  import bf_pkg::*;

  localparam int GRP_W = $clog2(GROUPS);

  // static settings
  logic retrip_en_reg;
  logic force_en_reg;
  status_e force_val_reg;
  logic [GRP_W-1:0] group_reg;
  res_sel_e res_sel_reg;
  logic [N_SIG-1:0] sig_mask_reg;
  logic [N_RELAY-1:0] do_mask_reg;
  logic [DLY_W-1:0] retrip_dly_reg;
  logic [DLY_W-1:0] fail_dly_reg;
  // per-group settings
  logic [PH_THR_W-1:0] ph_thr_reg [GROUPS];
  logic [MAG_W-1:0] res_thr_reg [GROUPS];
  mode_e mode_reg [GROUPS];
  // pick-up state
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic [2:0] ph_pu_reg;
  logic res_pu_reg;
  logic pickup_reg;
  logic blocked_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic start_reg;
  logic retrip_reg;
  logic fail_reg;
  status_e status_reg;

  logic [MAG_W-1:0] phase_mag [3];
  logic [MAG_W-1:0] res_mag;
  logic [PH_THR_W-1:0] ph_thr;
  logic [MAG_W-1:0] res_thr;
  mode_e mode;
  logic [2:0] ph_next;
  logic res_next;
  logic cur_hit;
  logic sig_hit;
  logic do_hit;
  logic raw_pu;
  logic pu_next;
  logic forced;
  status_e status_next;
  logic grp_sel;
  logic [GRP_W-1:0] grp_idx;

  bf_timer_if #(.W(DLY_W)) retrip_tmr ();
  bf_timer_if #(.W(DLY_W)) fail_tmr ();

  assign phase_mag[0] = PHASE_A_MAG;
  assign phase_mag[1] = PHASE_B_MAG;
  assign phase_mag[2] = PHASE_C_MAG;

  // 5 ms update tick
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == 32'(TICK_DIV - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
      tick_reg <= 1'b0;
    end
  end

  // register writes
  assign grp_sel = ADDR[GRP_BASE_BIT];
  assign grp_idx = GRP_W'(ADDR[GRP_BASE_BIT-1:2]);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      retrip_en_reg <= 1'b1;
      force_en_reg <= 1'b0;
      force_val_reg <= ST_NORMAL;
      group_reg <= '0;
      res_sel_reg <= RES_DISABLED;
      sig_mask_reg <= '0;
      do_mask_reg <= '0;
      retrip_dly_reg <= RETRIP_DLY_RST;
      fail_dly_reg <= FAIL_DLY_RST;
    end else if (WR && !grp_sel) begin
      case (ADDR)
        ADDR_CTRL: begin
          retrip_en_reg <= WDATA[CTRL_RETRIP_EN_BIT];
          force_en_reg <= WDATA[CTRL_FORCE_EN_BIT];
          force_val_reg <= status_e'(WDATA[CTRL_FORCE_LSB +: 3]);
          group_reg <= WDATA[CTRL_GROUP_BIT +: GRP_W];
        end
        ADDR_RES_SEL: res_sel_reg <= res_sel_e'(WDATA[1:0]);
        ADDR_SIG_MASK: sig_mask_reg <= WDATA[N_SIG-1:0];
        ADDR_DO_MASK: do_mask_reg <= WDATA[N_RELAY-1:0];
        ADDR_RETRIP_DLY: retrip_dly_reg <= WDATA[DLY_W-1:0];
        ADDR_FAIL_DLY: fail_dly_reg <= WDATA[DLY_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // group settings, one bank per setting group
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      for (int g = 0; g < GROUPS; g++) begin
        ph_thr_reg[g] <= PH_THR_RST;
        res_thr_reg[g] <= RES_THR_RST;
        mode_reg[g] <= MODE_CUR;
      end
    end else if (WR && grp_sel) begin
      case (ADDR[1:0])
        GRP_FIELD_PH: ph_thr_reg[grp_idx] <= WDATA[PH_THR_W-1:0];
        GRP_FIELD_RES: res_thr_reg[grp_idx] <= WDATA[MAG_W-1:0];
        GRP_FIELD_MODE: mode_reg[grp_idx] <= mode_e'(WDATA[3:0]);
        default: begin
        end
      endcase
    end
  end

  // register reads, data in the following cycle only
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rdata_reg <= '0;
    end else if (RD) begin
      rdata_reg <= '0;
      if (grp_sel) begin
        case (ADDR[1:0])
          GRP_FIELD_PH: rdata_reg <= DATA_W'(ph_thr_reg[grp_idx]);
          GRP_FIELD_RES: rdata_reg <= DATA_W'(res_thr_reg[grp_idx]);
          GRP_FIELD_MODE: rdata_reg <= DATA_W'(mode_reg[grp_idx]);
          default: rdata_reg <= '0;
        endcase
      end else begin
        case (ADDR)
          ADDR_CTRL: rdata_reg <= DATA_W'({group_reg, force_val_reg, force_en_reg,
                                           retrip_en_reg});
          ADDR_RES_SEL: rdata_reg <= DATA_W'(res_sel_reg);
          ADDR_SIG_MASK: rdata_reg <= DATA_W'(sig_mask_reg);
          ADDR_DO_MASK: rdata_reg <= DATA_W'(do_mask_reg);
          ADDR_RETRIP_DLY: rdata_reg <= DATA_W'(retrip_dly_reg);
          ADDR_FAIL_DLY: rdata_reg <= DATA_W'(fail_dly_reg);
          ADDR_STATUS: rdata_reg <= DATA_W'({res_pu_reg, ph_pu_reg, pickup_reg, status_reg});
          default: rdata_reg <= '0;
        endcase
      end
    end else begin
      rdata_reg <= '0;
    end
  end

  // comparators and mode combination
  always_comb begin
    ph_thr = ph_thr_reg[group_reg];
    res_thr = res_thr_reg[group_reg];
    mode = mode_reg[group_reg];
    for (int i = 0; i < 3; i++) begin
      if (ph_pu_reg[i]) begin
        ph_next[i] = !(32'(phase_mag[i]) * PCT_FULL <
                       32'(ph_thr) * PHASE_SCALE * RESET_RATIO_PCT);
      end else begin
        ph_next[i] = 32'(phase_mag[i]) > 32'(ph_thr) * PHASE_SCALE;
      end
    end
    case (res_sel_reg)
      RES_INPUT_ONE: res_mag = RESIDUAL_INPUT_ONE;
      RES_INPUT_TWO: res_mag = RESIDUAL_INPUT_TWO;
      RES_FROM_PHASES: res_mag = RESIDUAL_FROM_PHASES;
      default: res_mag = '0;
    endcase
    if (res_sel_reg == RES_DISABLED) begin
      res_next = 1'b0;
    end else if (res_pu_reg) begin
      res_next = !(32'(res_mag) * PCT_FULL < 32'(res_thr) * RESET_RATIO_PCT);
    end else begin
      res_next = res_mag > res_thr;
    end
    cur_hit = (|ph_next) | res_next;
    sig_hit = |(TRIP_SIGNALS & sig_mask_reg);
    do_hit = |(RELAY_STATES & do_mask_reg);
    case (mode)
      MODE_CUR: raw_pu = cur_hit;
      MODE_DO: raw_pu = do_hit;
      MODE_SIG: raw_pu = sig_hit;
      MODE_CUR_AND_DO: raw_pu = cur_hit & do_hit;
      MODE_CUR_AND_SIG: raw_pu = cur_hit & sig_hit;
      MODE_CUR_OR_SIG: raw_pu = cur_hit | sig_hit;
      MODE_CUR_OR_SIG_OR_DO: raw_pu = cur_hit | sig_hit | do_hit;
      MODE_SIG_OR_DO: raw_pu = sig_hit | do_hit;
      MODE_CUR_OR_DO: raw_pu = cur_hit | do_hit;
      MODE_CUR_AND_SIG_AND_DO: raw_pu = cur_hit & sig_hit & do_hit;
      default: raw_pu = 1'b0;
    endcase
    pu_next = raw_pu & !BLOCK;
  end

  // criteria sampled once per update
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ph_pu_reg <= '0;
      res_pu_reg <= 1'b0;
      pickup_reg <= 1'b0;
      blocked_reg <= 1'b0;
    end else if (tick_reg) begin
      ph_pu_reg <= ph_next;
      res_pu_reg <= res_next;
      pickup_reg <= pu_next;
      blocked_reg <= raw_pu & BLOCK;
    end
  end

  // one pick-up drives both timers
  assign retrip_tmr.tick = tick_reg;
  assign retrip_tmr.pickup = pu_next;
  assign retrip_tmr.delay = retrip_dly_reg;
  assign fail_tmr.tick = tick_reg;
  assign fail_tmr.pickup = pu_next;
  assign fail_tmr.delay = fail_dly_reg;

  bf_delay_timer #(.W(DLY_W)) u_retrip_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .tmr(retrip_tmr.timer)
  );

  bf_delay_timer #(.W(DLY_W)) u_fail_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .tmr(fail_tmr.timer)
  );

  // status and outputs
  assign forced = force_en_reg && (force_val_reg != ST_NORMAL);

  always_comb begin
    if (forced) begin
      status_next = force_val_reg;
    end else if (blocked_reg) begin
      status_next = ST_BLOCKED;
    end else if (pickup_reg && fail_tmr.expired) begin
      status_next = ST_FAILURE;
    end else if (pickup_reg && retrip_en_reg && retrip_tmr.expired) begin
      status_next = ST_RETRIP;
    end else if (pickup_reg) begin
      status_next = ST_START;
    end else begin
      status_next = ST_NORMAL;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      status_reg <= ST_NORMAL;
      start_reg <= 1'b0;
      retrip_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (forced) begin
        start_reg <= force_val_reg inside {ST_START, ST_RETRIP, ST_FAILURE};
        retrip_reg <= force_val_reg == ST_RETRIP;
        fail_reg <= force_val_reg == ST_FAILURE;
      end else begin
        start_reg <= pickup_reg;
        retrip_reg <= pickup_reg && retrip_en_reg && retrip_tmr.expired;
        fail_reg <= pickup_reg && fail_tmr.expired;
      end
    end
  end

  assign RDATA = rdata_reg;
  assign START = start_reg;
  assign RETRIP = retrip_reg;
  assign BREAKER_FAILURE_OUTPUT = fail_reg;
  assign STATUS = status_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence phase_over_s;
    tick_reg && !BLOCK && (mode == MODE_CUR) &&
    (32'(PHASE_A_MAG) > 32'(ph_thr) * PHASE_SCALE);
  endsequence

  phase_pickup_a: assert property (phase_over_s |=> pickup_reg && ph_pu_reg[0])
    else $error("phase above threshold did not pick up");
  hyst_hold_a: assert property (tick_reg && ph_pu_reg[0] &&
      (32'(PHASE_A_MAG) * PCT_FULL >= 32'(ph_thr) * PHASE_SCALE * RESET_RATIO_PCT)
      |=> ph_pu_reg[0])
    else $error("phase pick-up released above reset ratio");
  resid_off_a: assert property (tick_reg && res_sel_reg == RES_DISABLED |=> !res_pu_reg)
    else $error("disabled residual picked up");
  tick_only_a: assert property (!tick_reg |=> $stable(pickup_reg))
    else $error("pick-up changed outside update tick");
  sig_mode_a: assert property (tick_reg && !BLOCK && mode == MODE_SIG
      |=> pickup_reg == $past(sig_hit))
    else $error("signal mode pick-up mismatch");
  retrip_off_a: assert property (!retrip_en_reg && !forced |=> !RETRIP)
    else $error("retrip asserted while disabled");
  release_clear_a: assert property (tick_reg && !pu_next && !forced ##1 !forced
      |=> !RETRIP && !BREAKER_FAILURE_OUTPUT)
    else $error("outputs held after release");
  force_fail_a: assert property (forced && force_val_reg == ST_FAILURE
      |=> BREAKER_FAILURE_OUTPUT && STATUS == ST_FAILURE)
    else $error("forced failure not shown");
  block_start_a: assert property (tick_reg && BLOCK |=> !pickup_reg)
    else $error("pick-up while blocked");
endmodule // bf_pickup

// ### bench/fe_model.sv
/*
  front end model: phase and residual magnitudes, trip signals, relay states
  and block, launched at the edge after the bench sets each command.
  assumes one clock shared with the pick-up block.
*/
`timescale 1ns/1ps
module fe_model
  import bf_pkg::*;
(
  input wire logic CLK,
  input wire logic [5:0][bf_pkg::MAG_W-1:0] mag_cmd,
  input wire logic [15:0] bin_cmd,
  input wire logic blk_cmd,
  output logic [5:0][bf_pkg::MAG_W-1:0] mag = '0,
  output logic [7:0] trip = '0,
  output logic [7:0] relay = '0,
  output logic blk = 1'b0
);
  // levels change only just after an edge and hold until the next command
  always @(posedge CLK) begin
    mag <= mag_cmd;
    trip <= bin_cmd[7:0];
    relay <= bin_cmd[15:8];
    blk <= blk_cmd;
  end
endmodule // fe_model

// ### bench/tb_bf_pickup.sv
/*
  bench for the breaker failure pick-up block: register tasks, front end
  model and integer reference checks of pick-up, modes, timers and forcing.
  assumes bf_pkg and a short update period through TICK_DIV.
*/
`timescale 1ns/1ps
`define CHECK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("Error at %0t: got %h exp %h", $time, (g), (e)); \
  end \
end
module tb_bf_pickup;
  import bf_pkg::*;
  localparam int TD = 20;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [5:0][MAG_W-1:0] mag_cmd = '0;
  logic [5:0][MAG_W-1:0] mag;
  logic [15:0] bin_cmd = '0;
  logic blk_cmd = 1'b0;
  logic [7:0] trip;
  logic [7:0] relay;
  logic blk;
  logic start;
  logic retrip;
  logic bfo;
  logic [2:0] status;
  logic [15:0] lfsr = 16'd31776;
  int failures = 0;
  int n_tests = 0;
  int rst_a[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 15};
  int rst_v[12] = '{1, 0, 0, 0, 20, 40, 0, 0, 20, 1200, 0, 0};

  fe_model fe_model_inst (.CLK(CLK), .mag_cmd(mag_cmd), .bin_cmd(bin_cmd),
    .blk_cmd(blk_cmd), .mag(mag), .trip(trip), .relay(relay), .blk(blk));
  bf_pickup #(.N_SIG(8), .N_RELAY(8), .TICK_DIV(TD)) bf_pickup_inst (
    .CLK(CLK), .RESET_N(RESET_N), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PHASE_A_MAG(mag[0]), .PHASE_B_MAG(mag[1]), .PHASE_C_MAG(mag[2]),
    .RESIDUAL_INPUT_ONE(mag[3]), .RESIDUAL_INPUT_TWO(mag[4]),
    .RESIDUAL_FROM_PHASES(mag[5]), .TRIP_SIGNALS(trip), .RELAY_STATES(relay),
    .BLOCK(blk), .START(start), .RETRIP(retrip), .BREAKER_FAILURE_OUTPUT(bfo),
    .STATUS(status));

  initial begin
    forever #2.5 CLK = ~CLK;
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // reference combination of current, signal and relay criteria
  function automatic logic mode_ok(input int m, input logic c, input logic s, input logic d);
    case (m)
      0: return c;
      1: return d;
      2: return s;
      3: return c & d;
      4: return c & s;
      5: return c | s;
      6: return c | s | d;
      7: return s | d;
      8: return c | d;
      default: return c & s & d;
    endcase
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input int a, input int d);
    @(posedge CLK);
    addr <= ADDR_W'(a);
    wdata <= DATA_W'(d);
    wr <= 1'b1;
    @(posedge CLK);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input int a, output logic [DATA_W-1:0] d);
    @(posedge CLK);
    addr <= ADDR_W'(a);
    rd <= 1'b1;
    @(posedge CLK);
    rd <= 1'b0;
    @(negedge CLK);
    d = rdata;
  endtask

  task automatic ticks(input int n);
    repeat (n * TD) @(posedge CLK);
  endtask

  task automatic set_mag(input int i, input int v);
    @(posedge CLK);
    mag_cmd[i] <= MAG_W'(v);
  endtask

  task automatic clr();
    @(posedge CLK);
    mag_cmd <= '0;
    ticks(2);
  endtask

  task automatic bound(input int c, input int lim);
    if (c >= lim) begin
      failures++;
      complete_run();
    end
  endtask

  // cycles from start to retrip and to failure, delays 3 and 6 updates
  task automatic meas(input int ex_ret);
    int c;
    int cr;
    c = 0;
    cr = -1;
    set_mag(0, 300);
    while (start !== 1'b1 && c < 3 * TD) begin
      @(posedge CLK);
      #1;
      c++;
    end
    bound(c, 3 * TD);
    c = 0;
    while (bfo !== 1'b1 && c < 1000) begin
      @(posedge CLK);
      #1;
      c++;
      if (retrip === 1'b1 && cr < 0) begin
        cr = c;
      end
    end
    bound(c, 1000);
    `CHECK(c, 6 * TD)
    `CHECK(cr, ex_ret)
    `CHECK(status, ST_FAILURE)
    clr();
    `CHECK({start, retrip, bfo}, 3'b000)
    $display("test timers done");
  endtask

  initial begin
    logic [DATA_W-1:0] d;
    int v;
    logic pv;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    foreach (rst_a[i]) begin
      rd_reg(rst_a[i], d);
      `CHECK(d, rst_v[i])
    end
    $display("test reset values done");
    pv = 1'b0;
    repeat (12) begin
      lfsr = nxt(lfsr);
      v = 190 + lfsr % 20;
      pv = pv ? (v * PCT_FULL >= 200 * RESET_RATIO_PCT) : (v > 200);
      set_mag(0, v);
      ticks(2);
      rd_reg(ADDR_STATUS, d);
      `CHECK({d[3], d[4], start}, {3{pv}})
    end
    clr();
    $display("test hysteresis done");
    for (int sel = 0; sel < 4; sel++) begin
      wr_reg(ADDR_RES_SEL, sel);
      for (int i = 3; i < 6; i++) begin
        lfsr = nxt(lfsr);
        set_mag(i, lfsr % 2400);
      end
      ticks(2);
      rd_reg(ADDR_STATUS, d);
      `CHECK(d[7], sel > 0 && mag_cmd[sel + 2] > RES_THR_RST)
      clr();
    end
    wr_reg(ADDR_RES_SEL, 0);
    $display("test residual done");
    wr_reg(ADDR_SIG_MASK, 'h05);
    wr_reg(ADDR_DO_MASK, 'h0a);
    for (int m = 0; m < 10; m++) begin
      wr_reg('ha, m);
      for (int k = 0; k < 8; k++) begin
        lfsr = nxt(lfsr);
        @(posedge CLK);
        bin_cmd <= (lfsr & 16'hf5fa) | {6'h0, k[2], 6'h0, k[1], 2'h0};
        mag_cmd <= k[0] ? (96'd300 << (16 * (k % 3))) : '0;
        ticks(2);
        `CHECK(start, mode_ok(m, k[0], k[1], k[2]))
      end
    end
    wr_reg('ha, 0);
    clr();
    $display("test modes done");
    wr_reg(ADDR_RETRIP_DLY, 3);
    wr_reg(ADDR_FAIL_DLY, 6);
    meas(3 * TD);
    wr_reg(ADDR_CTRL, 0);
    meas(-1);
    wr_reg(ADDR_CTRL, 1);
    wr_reg('hc, 50);
    set_mag(1, 300);
    ticks(2);
    `CHECK(start, 1'b1)
    wr_reg(ADDR_CTRL, 'h21);
    ticks(2);
    `CHECK(start, 1'b0)
    rd_reg(ADDR_SIG_MASK, d);
    `CHECK(d, 20'h00005)
    wr_reg(ADDR_CTRL, 1);
    @(posedge CLK);
    blk_cmd <= 1'b1;
    ticks(2);
    `CHECK({start, status}, {1'b0, ST_BLOCKED})
    @(posedge CLK);
    blk_cmd <= 1'b0;
    clr();
    $display("test group and block done");
    for (int st = 1; st < 5; st++) begin
      wr_reg(ADDR_CTRL, 1 | st << 2);
      ticks(2);
      `CHECK(status, ST_NORMAL)
      wr_reg(ADDR_CTRL, 3 | st << 2);
      ticks(2);
      `CHECK({start, retrip, bfo, status}, {st < 4, st == 2, st == 3, 3'(st)})
    end
    $display("test forcing done");
    complete_run();
  end
endmodule // tb_bf_pickup
